//--- design/dsfl_pkg.sv
// Package for the drive stop sequencer and frequency clamp.
// Frequencies are in 0.01 Hz units, times in 0.01 s units.
package dsfl_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	// Tick counter needs 19 bits for a 10 ms period at 40 MHz
	localparam logic [18:0] TICK_LAST = 19'(TICK_CYC - 1);

	// Wishbone word offsets (byte addresses)
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_DCFREQ = 8'h04;
	localparam logic [7:0] ADR_BLOCKT = 8'h08;
	localparam logic [7:0] ADR_BRAKET = 8'h0c;
	localparam logic [7:0] ADR_BRAKEAMT = 8'h10;
	localparam logic [7:0] ADR_STARTF = 8'h14;
	localparam logic [7:0] ADR_MAXF = 8'h18;
	localparam logic [7:0] ADR_LIMLO = 8'h1c;
	localparam logic [7:0] ADR_LIMHI = 8'h20;
	localparam logic [7:0] ADR_DWELLF = 8'h24;
	localparam logic [7:0] ADR_DECSTEP = 8'h28;
	localparam logic [7:0] ADR_AMTMAX = 8'h2c;
	localparam logic [7:0] ADR_STATUS = 8'h30;
	localparam logic [7:0] ADR_OUTF = 8'h34;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_LIMEN_BIT = 4;
	localparam int CTRL_STALL_BIT = 5;
	localparam int CTRL_PB_REACC_BIT = 6;

	// Stop mode codes
	localparam logic [2:0] MODE_DEC = 3'h0;
	localparam logic [2:0] MODE_DCBRAKE = 3'h1;
	localparam logic [2:0] MODE_FREE = 3'h2;
	localparam logic [2:0] MODE_PBRAKE = 3'h4;
	localparam logic [2:0] MODE_MAX = 3'h4;

	// Reset values
	localparam logic [15:0] RST_DCFREQ = 16'h01f4;
	localparam logic [15:0] RST_BLOCKT = 16'h000a;
	localparam logic [15:0] RST_BRAKET = 16'h0064;
	localparam logic [15:0] RST_BRAKEAMT = 16'h0032;
	localparam logic [15:0] RST_STARTF = 16'h0032;
	localparam logic [15:0] RST_MAXF = 16'h1770;
	localparam logic [15:0] RST_LIMLO = 16'h0032;
	localparam logic [15:0] RST_DWELLF = 16'h0000;
	localparam logic [15:0] RST_DECSTEP = 16'h0001;
	localparam logic [15:0] RST_AMTMAX = 16'h0096;

	// Setting limits
	localparam logic [15:0] DCFREQ_MAX = 16'h1770;
	localparam logic [15:0] TIME_MAX = 16'h1770;
	localparam logic [15:0] STARTF_MIN = 16'h0001;
	localparam logic [15:0] STARTF_MAX = 16'h03e8;
	localparam logic [15:0] MAXF_MIN = 16'h0fa0;
	localparam logic [15:0] MAXF_MAX = 16'h9c40;

	typedef enum logic [2:0] {
		DSFL_IDLE,
		DSFL_RUN,
		DSFL_DECEL,
		DSFL_BLOCK,
		DSFL_DCBRAKE
	} dsfl_state_e;
endpackage : dsfl_pkg

//--- design/dsfl_sync2.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is clk_i.
`timescale 1ns/1ps
module dsfl_sync2 (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Level
	input wire logic d_i,
	output logic q_o
);
	logic [1:0] stage;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stage <= 2'h0;
		end else begin
			stage <= {stage[0], d_i};
		end
	end
	assign q_o = stage[1];
endmodule : dsfl_sync2

//--- design/dsfl_clamp.sv
// Combinational clamp of a requested frequency.
// Assumes settings are already range-limited by the register file.
`timescale 1ns/1ps
module dsfl_clamp (
	// Settings
	input wire logic [15:0] start_freq_floor_i,
	input wire logic [15:0] max_freq_cap_i,
	input wire logic lim_en_i,
	input wire logic [15:0] lim_lo_i,
	input wire logic [15:0] lim_hi_i,
	// Request and result
	input wire logic [15:0] req_i,
	output logic [15:0] freq_o
);
	logic [15:0] capped;
	always_comb begin
		capped = req_i;
		if (lim_en_i && capped > lim_hi_i) begin
			capped = lim_hi_i;
		end
		if (lim_en_i && capped < lim_lo_i) begin
			capped = lim_lo_i;
		end
		if (capped > max_freq_cap_i) begin
			capped = max_freq_cap_i;
		end
		if (capped < start_freq_floor_i) begin
			capped = 16'h0000;
		end
		freq_o = capped;
	end
endmodule : dsfl_clamp

//--- design/dsfl_top.sv
// Stop-mode sequencer and frequency clamp of a motor drive.
// Assumes a classic Wishbone master on clk_i and async run/overvoltage pins.
`timescale 1ns/1ps
module dsfl_top
	import dsfl_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Drive pins
	input wire logic run_i,
	input wire logic dc_overvolt_i,
	input wire logic [15:0] freq_req_i,
	// Drive outputs
	output logic [15:0] out_freq_o,
	output logic out_en_o,
	output logic dc_inject_o,
	output logic [15:0] dc_amount_o,
	output logic stall_act_o,
	output logic pbrake_act_o
);
	typedef struct packed {
		logic [2:0] mode;
		logic lim_en;
		logic stall_prevention_select;
		logic pb_reacc;
		logic [15:0] dc_freq;
		logic [15:0] block_t;
		logic [15:0] brake_t;
		logic [15:0] brake_amt;
		logic [15:0] start_freq_floor;
		logic [15:0] max_freq_cap;
		logic [15:0] lim_lo;
		logic [15:0] lim_hi;
		logic [15:0] dwell_f;
		logic [15:0] dec_step;
		logic [15:0] amt_max;
		dsfl_state_e state;
		logic [18:0] tick_cnt;
		logic [15:0] phase_cnt;
		logic [15:0] freq;
		logic [31:0] rdata;
		logic ack;
		logic out_en;
		logic dc_inject;
		logic [15:0] dc_amount;
		logic stall_act;
		logic pbrake_act;
	} dsfl_regs_s;

	dsfl_regs_s r;
	dsfl_regs_s next_r;
	logic run_s;
	logic ov_s;
	logic [15:0] target;
	logic tick;
	logic wr;
	// Carry kept so reacceleration cannot wrap past the cap
	logic [16:0] up_sum;
	logic [15:0] half_step;

	dsfl_sync2 u_sync_run (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(run_i),
		.q_o(run_s)
	);
	dsfl_sync2 u_sync_ov (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(dc_overvolt_i),
		.q_o(ov_s)
	);
	// Request bus is a parameter word, assumed quasi-static
	dsfl_clamp u_clamp (
		.start_freq_floor_i(r.start_freq_floor),
		.max_freq_cap_i(r.max_freq_cap),
		.lim_en_i(r.lim_en),
		.lim_lo_i(r.lim_lo),
		.lim_hi_i(r.lim_hi),
		.req_i(freq_req_i),
		.freq_o(target)
	);

	assign tick = (r.tick_cnt == TICK_LAST);
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack;
	assign up_sum = {1'b0, r.freq} + {1'b0, r.dec_step};
	assign half_step = {1'b0, r.dec_step[15:1]};

	always_comb begin
		next_r = r;
		next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
		next_r.tick_cnt = tick ? 19'h00000 : r.tick_cnt + 19'h00001;
		// Register writes, whole word when the low lanes are enabled
		if (wr && wb_sel_i[1:0] == 2'b11) begin
			if (wb_adr_i == ADR_CTRL) begin
				if (wb_dat_i[2:0] <= MODE_MAX) begin
					next_r.mode = wb_dat_i[2:0];
				end
				next_r.lim_en = wb_dat_i[CTRL_LIMEN_BIT];
				next_r.stall_prevention_select = wb_dat_i[CTRL_STALL_BIT];
				next_r.pb_reacc = wb_dat_i[CTRL_PB_REACC_BIT];
			end else if (wb_adr_i == ADR_DCFREQ) begin
				next_r.dc_freq = (wb_dat_i[15:0] > DCFREQ_MAX) ? DCFREQ_MAX : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_BLOCKT) begin
				next_r.block_t = (wb_dat_i[15:0] > TIME_MAX) ? TIME_MAX : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_BRAKET) begin
				next_r.brake_t = (wb_dat_i[15:0] > TIME_MAX) ? TIME_MAX : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_BRAKEAMT) begin
				// Capped by drive/motor current ratio
				next_r.brake_amt = (wb_dat_i[15:0] > r.amt_max) ? r.amt_max : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_STARTF) begin
				if (wb_dat_i[15:0] >= STARTF_MIN && wb_dat_i[15:0] <= STARTF_MAX) begin
					next_r.start_freq_floor = wb_dat_i[15:0];
				end
			end else if (wb_adr_i == ADR_MAXF) begin
				if (wb_dat_i[15:0] >= MAXF_MIN && wb_dat_i[15:0] <= MAXF_MAX) begin
					next_r.max_freq_cap = wb_dat_i[15:0];
					if (r.lim_hi > wb_dat_i[15:0]) begin
						next_r.lim_hi = wb_dat_i[15:0];
					end
					if (r.lim_lo > wb_dat_i[15:0]) begin
						next_r.lim_lo = wb_dat_i[15:0];
					end
				end
			end else if (wb_adr_i == ADR_LIMLO) begin
				next_r.lim_lo = (wb_dat_i[15:0] > r.max_freq_cap) ? r.max_freq_cap : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_LIMHI) begin
				next_r.lim_hi = (wb_dat_i[15:0] > r.max_freq_cap) ? r.max_freq_cap : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_DWELLF) begin
				next_r.dwell_f = wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_DECSTEP) begin
				next_r.dec_step = (wb_dat_i[15:0] == 16'h0000) ? RST_DECSTEP : wb_dat_i[15:0];
			end else if (wb_adr_i == ADR_AMTMAX) begin
				next_r.amt_max = wb_dat_i[15:0];
				if (r.brake_amt > wb_dat_i[15:0]) begin
					next_r.brake_amt = wb_dat_i[15:0];
				end
			end
		end
		// Read mux; unmapped reads return zero
		next_r.rdata = 32'h0000_0000;
		if (wb_adr_i == ADR_CTRL) begin
			next_r.rdata = {25'h0, r.pb_reacc, r.stall_prevention_select, r.lim_en, 1'b0, r.mode};
		end else if (wb_adr_i == ADR_DCFREQ) begin
			next_r.rdata = {16'h0, r.dc_freq};
		end else if (wb_adr_i == ADR_BLOCKT) begin
			next_r.rdata = {16'h0, r.block_t};
		end else if (wb_adr_i == ADR_BRAKET) begin
			next_r.rdata = {16'h0, r.brake_t};
		end else if (wb_adr_i == ADR_BRAKEAMT) begin
			next_r.rdata = {16'h0, r.brake_amt};
		end else if (wb_adr_i == ADR_STARTF) begin
			next_r.rdata = {16'h0, r.start_freq_floor};
		end else if (wb_adr_i == ADR_MAXF) begin
			next_r.rdata = {16'h0, r.max_freq_cap};
		end else if (wb_adr_i == ADR_LIMLO) begin
			next_r.rdata = {16'h0, r.lim_lo};
		end else if (wb_adr_i == ADR_LIMHI) begin
			next_r.rdata = {16'h0, r.lim_hi};
		end else if (wb_adr_i == ADR_DWELLF) begin
			next_r.rdata = {16'h0, r.dwell_f};
		end else if (wb_adr_i == ADR_DECSTEP) begin
			next_r.rdata = {16'h0, r.dec_step};
		end else if (wb_adr_i == ADR_AMTMAX) begin
			next_r.rdata = {16'h0, r.amt_max};
		end else if (wb_adr_i == ADR_STATUS) begin
			next_r.rdata = {24'h0, r.pbrake_act, r.stall_act, r.dc_inject, r.out_en,
				1'b0, r.state};
		end else if (wb_adr_i == ADR_OUTF) begin
			next_r.rdata = {16'h0, r.freq};
		end

		// Stop sequencer
		next_r.stall_act = 1'b0;
		next_r.pbrake_act = 1'b0;
		case (r.state)
			DSFL_IDLE: begin
				next_r.freq = 16'h0000;
				next_r.out_en = 1'b0;
				next_r.dc_inject = 1'b0;
				if (run_s) begin
					next_r.state = DSFL_RUN;
					next_r.out_en = 1'b1;
				end
			end
			DSFL_RUN: begin
				next_r.out_en = 1'b1;
				next_r.freq = target;
				if (!run_s) begin
					if (r.mode == MODE_FREE) begin
						next_r.state = DSFL_IDLE;
						next_r.out_en = 1'b0;
						next_r.freq = 16'h0000;
					end else begin
						next_r.state = DSFL_DECEL;
					end
				end
			end
			DSFL_DECEL: begin
				if (run_s) begin
					next_r.state = DSFL_RUN;
				end else if (r.mode == MODE_DCBRAKE && r.freq <= r.dc_freq) begin
					// Dwell below braking point is never entered
					next_r.state = DSFL_BLOCK;
					next_r.out_en = 1'b0;
					next_r.phase_cnt = 16'h0000;
				end else if (r.freq == 16'h0000) begin
					next_r.state = DSFL_IDLE;
					next_r.out_en = 1'b0;
				end else if (tick) begin
					if (r.mode == MODE_PBRAKE && ov_s) begin
						next_r.pbrake_act = 1'b1;
						if (r.pb_reacc) begin
							next_r.freq = (up_sum > {1'b0, r.max_freq_cap}) ?
								r.max_freq_cap : up_sum[15:0];
						end else begin
							next_r.freq = (r.freq > half_step) ?
								r.freq - half_step : 16'h0000;
						end
					end else if (r.stall_prevention_select && ov_s) begin
						next_r.stall_act = 1'b1;
					end else begin
						next_r.freq = (r.freq > r.dec_step) ? r.freq - r.dec_step : 16'h0000;
					end
				end
			end
			DSFL_BLOCK: begin
				next_r.out_en = 1'b0;
				next_r.freq = 16'h0000;
				if (run_s) begin
					next_r.state = DSFL_RUN;
				end else if (r.phase_cnt >= r.block_t) begin
					next_r.state = DSFL_DCBRAKE;
					next_r.phase_cnt = 16'h0000;
					next_r.dc_inject = 1'b1;
					next_r.dc_amount = r.brake_amt;
				end else if (tick) begin
					next_r.phase_cnt = r.phase_cnt + 16'h0001;
				end
			end
			DSFL_DCBRAKE: begin
				if (run_s || r.phase_cnt >= r.brake_t) begin
					next_r.state = run_s ? DSFL_RUN : DSFL_IDLE;
					next_r.dc_inject = 1'b0;
					next_r.dc_amount = 16'h0000;
				end else if (tick) begin
					next_r.phase_cnt = r.phase_cnt + 16'h0001;
				end
			end
			default: begin
				next_r.state = DSFL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '0;
			r.mode <= MODE_DEC;
			r.lim_en <= 1'b0;
			r.dc_freq <= RST_DCFREQ;
			r.block_t <= RST_BLOCKT;
			r.brake_t <= RST_BRAKET;
			r.brake_amt <= RST_BRAKEAMT;
			r.start_freq_floor <= RST_STARTF;
			r.max_freq_cap <= RST_MAXF;
			r.lim_lo <= RST_LIMLO;
			r.lim_hi <= RST_MAXF;
			r.dwell_f <= RST_DWELLF;
			r.dec_step <= RST_DECSTEP;
			r.amt_max <= RST_AMTMAX;
			r.state <= DSFL_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign wb_dat_o = r.rdata;
	assign wb_ack_o = r.ack;
	assign out_freq_o = r.freq;
	assign out_en_o = r.out_en;
	assign dc_inject_o = r.dc_inject;
	assign dc_amount_o = r.dc_amount;
	assign stall_act_o = r.stall_act;
	assign pbrake_act_o = r.pbrake_act;
endmodule : dsfl_top

//--- sim/dsfl_monitor.sv
// Port-level checks on the Wishbone handshake and the stop sequencer outputs.
// Assumes binding to dsfl_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module dsfl_monitor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Drive outputs
	input wire logic out_en_o,
	input wire logic dc_inject_o,
	input wire logic [15:0] dc_amount_o,
	input wire logic stall_act_o,
	input wire logic pbrake_act_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_HOLE: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h3c |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	AST_AMT_ZERO: assert property (!dc_inject_o |-> dc_amount_o == 16'h0000)
		else $error("brake amount outside braking");
	AST_BLOCK_FIRST: assert property ($rose(dc_inject_o) |-> !$past(out_en_o))
		else $error("braking without output block");
	AST_INJ_DARK: assert property (dc_inject_o |-> !out_en_o)
		else $error("DC braking with output enabled");
	AST_PB_WINS: assert property (!(pbrake_act_o && stall_act_o))
		else $error("stall and power braking together");
	AST_PB_DECEL: assert property (pbrake_act_o |-> out_en_o && !dc_inject_o)
		else $error("power braking outside deceleration");
	AST_PB_PULSE: assert property (pbrake_act_o |=> !pbrake_act_o)
		else $error("power braking pulse too long");
	AST_ST_PULSE: assert property (stall_act_o |=> !stall_act_o)
		else $error("stall pulse too long");
endmodule : dsfl_monitor

bind dsfl_top dsfl_monitor dsfl_monitor_inst (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .out_en_o, .dc_inject_o, .dc_amount_o, .stall_act_o,
	.pbrake_act_o);

//--- sim/dsfl_motor.sv
// Behavioural motor and load on the drive outputs.
// Assumes regen_i is commanded by the bench to model a heavy load.
`timescale 1ns/1ps
module dsfl_motor (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Drive side
	input wire logic [15:0] out_freq_i,
	input wire logic out_en_i,
	input wire logic dc_inject_i,
	input wire logic regen_i,
	// Feedback
	output logic dc_overvolt_o,
	output logic [15:0] speed_o
);
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			speed_o <= 16'h0000;
			dc_overvolt_o <= 1'b0;
		end else begin
			// Coasting or DC braking bleeds speed off
			if (out_en_i && !dc_inject_i)
				speed_o <= out_freq_i;
			else if (speed_o != 16'h0000)
				speed_o <= speed_o - 16'h0001;
			// Heavy load pumps the bus when slowed by the drive
			dc_overvolt_o <= regen_i && out_en_i && (out_freq_i < speed_o);
		end
	end
endmodule : dsfl_motor

//--- sim/dsfl_top_bench.sv
// Self-checking bench for the stop sequencer and frequency clamp.
// Assumes the motor model on the drive outputs and a 40 MHz clock.
`timescale 1ns/1ps
module dsfl_top_bench
	import dsfl_pkg::*;
;
	logic clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, run_i = 0, regen = 0;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, rd;
	logic [15:0] freq_req_i = 0, lfsr = 16'h000b, req;
	logic [31:0] wb_dat_o;
	logic [15:0] out_freq_o, dc_amount_o;
	logic wb_ack_o, out_en_o, dc_inject_o, stall_act_o, pbrake_act_o, ovl;
	int err_total = 0, samples_checked = 0;
	logic [7:0] ad [12] = '{ADR_CTRL, ADR_DCFREQ, ADR_BLOCKT, ADR_BRAKET, ADR_BRAKEAMT, ADR_STARTF,
		ADR_MAXF, ADR_LIMLO, ADR_LIMHI, ADR_DWELLF, ADR_DECSTEP, ADR_AMTMAX};
	logic [15:0] dv [12] = '{16'h0000, RST_DCFREQ, RST_BLOCKT, RST_BRAKET, RST_BRAKEAMT, RST_STARTF,
		RST_MAXF, RST_LIMLO, RST_MAXF, RST_DWELLF, RST_DECSTEP, RST_AMTMAX};
	logic [15:0] corner [3] = '{16'h0031, 16'h0032, 16'hffff};

	dsfl_top dsfl_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_i(run_i),
		.dc_overvolt_i(ovl), .freq_req_i(freq_req_i), .out_freq_o(out_freq_o),
		.out_en_o(out_en_o), .dc_inject_o(dc_inject_o), .dc_amount_o(dc_amount_o),
		.stall_act_o(stall_act_o), .pbrake_act_o(pbrake_act_o));
	dsfl_motor dsfl_motor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .out_freq_i(out_freq_o),
		.out_en_i(out_en_o), .dc_inject_i(dc_inject_o), .regen_i(regen),
		.dc_overvolt_o(ovl), .speed_o());

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt

	function automatic logic [15:0] clampf(input logic [15:0] r, input logic le,
		input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] mx);
		logic [15:0] v;
		v = r;
		if (le && v < lo) v = lo;
		if (le && v > hi) v = hi;
		if (v > mx) v = mx;
		if (v < RST_STARTF) v = 16'h0000;
		return v;
	endfunction : clampf

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hf;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	task automatic setrun(input logic r);
		run_i <= r;
		repeat (5) @(posedge clk_i);
	endtask : setrun

	task automatic results;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	initial begin
		repeat (60000) @(posedge clk_i);
		err_total++;
		results();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		foreach (ad[i]) rdchk(ad[i], {16'h0, dv[i]});
		rdchk(8'h3c, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h5);
		rdchk(ADR_CTRL, 32'h0);
		wb(1'b1, ADR_BRAKEAMT, 32'hc8);
		rdchk(ADR_BRAKEAMT, {16'h0, RST_AMTMAX});
		wb(1'b1, ADR_MAXF, 32'h0f9f);
		rdchk(ADR_MAXF, {16'h0, RST_MAXF});
		wb(1'b1, ADR_MAXF, {16'h0, MAXF_MIN});
		wb(1'b1, ADR_LIMLO, 32'h0100);
		wb(1'b1, ADR_LIMHI, 32'h0800);
		for (int p = 0; p < 2; p++) begin
			wb(1'b1, ADR_CTRL, {27'h0, p[0], 1'b0, MODE_FREE});
			for (int k = 0; k < 11; k++) begin
				lfsr = nxt(lfsr);
				req = (k < 3) ? corner[k] : lfsr;
				freq_req_i <= req;
				setrun(1'b1);
				chk(out_freq_o, clampf(req, p[0], 16'h0100, 16'h0800, MAXF_MIN));
				chk(out_en_o, 1'b1);
			end
			run_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			chk({out_en_o, out_freq_o}, 17'h0);
		end
		wb(1'b1, ADR_CTRL, {29'h0, MODE_DEC});
		freq_req_i <= 16'h0400;
		setrun(1'b1);
		regen <= 1'b1;
		setrun(1'b0);
		rdchk(ADR_STATUS, 32'h12);
		setrun(1'b1);
		rdchk(ADR_STATUS, 32'h11);
		wb(1'b1, ADR_CTRL, {29'h0, MODE_DCBRAKE});
		freq_req_i <= 16'h0100;
		setrun(1'b1);
		setrun(1'b0);
		rdchk(ADR_STATUS, 32'h03);
		chk({out_en_o, dc_inject_o}, 2'b00);
		setrun(1'b1);
		rdchk(ADR_STATUS, 32'h11);
		wb(1'b1, ADR_BLOCKT, 32'h0);
		wb(1'b1, ADR_BRAKET, 32'h0);
		run_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk({out_en_o, dc_inject_o, dc_amount_o}, {2'b01, RST_AMTMAX});
		rdchk(ADR_STATUS, 32'h00);
		setrun(1'b1);
		wb(1'b1, ADR_CTRL, {25'h0, 1'b1, 1'b1, 2'b00, MODE_PBRAKE});
		rdchk(ADR_CTRL, {25'h0, 1'b1, 1'b1, 2'b00, MODE_PBRAKE});
		setrun(1'b0);
		rdchk(ADR_STATUS, 32'h12);
		results();
	end
endmodule : dsfl_top_bench
